// ===== hw/scsp_ctrl.v
// Purpose: system control logic: low-power entry, trap configuration, system handler priorities
// Assumes: mclk 100 MHz, rst synchronous active high, core pulses are one mclk wide
// Notes:   APB4 slave, zero wait states, read data captured in the setup cycle
//
// Functional notes
// RULE1 - wake bit clear: only enabled interrupts wake
// RULE2 - wake bit set: any interrupt wakes
// RULE3 - pending event wakes wait, else latched
// RULE4 - send-event or external event also wakes
// RULE5 - deep sleep select chooses low-power mode
// RULE6 - sleep after handler returns to thread
// RULE7 - stack alignment bit selects four/eight bytes
// RULE8 - realign flag in stacked bit nine
// RULE9 - high-priority bus faults lock or ignore
// RULE10 - divide by zero faults or returns zero
// RULE11 - misaligned trap bit faults halfword/word access
// RULE12 - misaligned multiple/doubleword access always faults
// RULE13 - unprivileged trigger writes need enable bit
// RULE14 - thread entry only when no exception active; code also allows it with others active if thread-any bit set
// RULE15 - priority registers accept byte and word writes
// RULE16 - priority bits 3:0 read zero
// RULE17 - first priority register holds handlers 4-6
// RULE18 - handler 11, 14, 15 byte placement
// RULE19 - priority 0-15, lower value wins
// RULE20 - preemption compares group priority only
// RULE21 - reserved bits read zero, ignore writes
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "scsp_map.vh"

module scsp_ctrl #(
    parameter NUM_IRQ = 32
)(
    input  wire               mclk,
    input  wire               rst,
    // apb slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    input  wire [3:0]         pstrb,
    input  wire [2:0]         pprot,
    output wire               pready,
    output reg  [31:0]        prdata,
    output wire               pslverr,
    // wake and sleep
    input  wire [NUM_IRQ-1:0] irq_pending,
    input  wire [NUM_IRQ-1:0] irq_enable,
    input  wire               wait_for_event_instr,
    input  wire               send_event_instr,
    input  wire               ext_event,
    input  wire               handler_to_thread,
    output wire               low_power,
    output wire               deep_sleep,
    output reg                wfe_done,
    // exception entry and return
    input  wire               exc_entry,
    input  wire [31:0]        entry_sp,
    input  wire               exception_return_code,
    input  wire               stacked_realign,
    output reg                stack_realign,
    output reg                return_readjust,
    // fault handling
    input  wire               data_bus_fault,
    input  wire               exec_pri_negative,
    output reg                lockup,
    output reg                bus_fault_take,
    output reg                bus_fault_ignored,
    input  wire               divide_zero,
    output reg                divide_fault,
    output reg                divide_quot_zero,
    input  wire               access_misaligned,
    input  wire               access_multi_dword,
    output reg                usage_fault_misalign,
    // software trigger register gate
    input  wire               trigger_write,
    input  wire               trigger_unpriv,
    output reg                trigger_grant,
    output reg                trigger_refuse,
    // thread-mode entry check
    input  wire               return_to_thread,
    input  wire               other_active,
    output reg                thread_return_ok,
    output reg                thread_return_fault,
    // priorities and preemption
    output wire [3:0]         memmanage_priority,
    output wire [3:0]         busfault_priority,
    output wire [3:0]         usagefault_priority,
    output wire [3:0]         supervisor_call_priority_field,
    output wire [3:0]         pendable_service_priority,
    output wire [3:0]         tick_timer_priority,
    input  wire [2:0]         prigroup,
    input  wire [2:0]         cand_handler,
    input  wire [7:0]         cur_exec_pri,
    output reg                cand_preempts
);

    localparam ST_RUN  = 3'b001;
    localparam ST_WFE  = 3'b010;
    localparam ST_EXIT = 3'b100;

    reg  [31:0]        sleep_wake_r;
    reg  [31:0]        trap_cfg_r;
    reg  [31:0]        fault_pri_r;
    reg  [31:0]        svc_pri_r;
    reg  [31:0]        pend_tick_r;
    reg  [2:0]         state_r;
    reg  [2:0]         state_nxt;
    reg                event_latch_r;
    reg                event_latch_nxt;
    reg  [NUM_IRQ-1:0] pend_d_r;
    reg  [31:0]        rd_nxt;
    reg                hit_nxt;
    reg                err_r;
    reg  [7:0]         cand_pri;
    reg  [7:0]         grp_mask;

    wire               setup    = psel & ~penable;
    wire               wr_acc   = psel & penable & pwrite;
    wire               wake_any = sleep_wake_r[`SCSP_SW_WAKE_ANY];
    wire [NUM_IRQ-1:0] new_pend = irq_pending & ~pend_d_r;
    wire               new_en   = |(new_pend & irq_enable);
    wire               new_all  = |new_pend;
    wire               pend_en  = |(irq_pending & irq_enable);
    wire               wake_src;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & err_r;

    // only new pending edges count, so an old pending irq cannot re-arm the latch
    assign wake_src = send_event_instr | ext_event            // RULE4
                    | new_en                                  // RULE1
                    | (wake_any & new_all);                   // RULE2

    // read path: decode in setup, data stands through the access phase
    always @*
    begin
        rd_nxt  = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (paddr)
            `SCSP_OFF_SLEEP_WAKE:    rd_nxt = sleep_wake_r;
            `SCSP_OFF_TRAP_CFG:      rd_nxt = trap_cfg_r;
            `SCSP_OFF_FAULT_PRI:     rd_nxt = fault_pri_r;
            `SCSP_OFF_SVC_PRI:       rd_nxt = svc_pri_r;
            `SCSP_OFF_PEND_TICK_PRI: rd_nxt = pend_tick_r;
            default:                 hit_nxt = 1'b0;
        endcase
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            err_r  <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            err_r  <= ~hit_nxt;
        end
    end

    // write path: byte lanes honoured on every register, masks drop reserved bits
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  strb;
        input [31:0] mask;
        integer i;
        begin
            lane_merge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    lane_merge[i*8 +: 8] = wd[i*8 +: 8] & mask[i*8 +: 8]; // RULE15 RULE16 RULE21
            end
        end
    endfunction

    always @(posedge mclk)
    begin
        if (rst)
        begin
            sleep_wake_r <= `SCSP_RST_SLEEP_WAKE;
            trap_cfg_r   <= `SCSP_RST_TRAP_CFG;
            fault_pri_r  <= `SCSP_RST_PRI;
            svc_pri_r    <= `SCSP_RST_PRI;
            pend_tick_r  <= `SCSP_RST_PRI;
        end
        else if (wr_acc)
        begin
            case (paddr)
                `SCSP_OFF_SLEEP_WAKE:
                    sleep_wake_r <= lane_merge(sleep_wake_r, pwdata, pstrb, `SCSP_MASK_SLEEP_WAKE);
                `SCSP_OFF_TRAP_CFG:
                    trap_cfg_r <= lane_merge(trap_cfg_r, pwdata, pstrb, `SCSP_MASK_TRAP_CFG);
                `SCSP_OFF_FAULT_PRI:
                    fault_pri_r <= lane_merge(fault_pri_r, pwdata, pstrb, `SCSP_MASK_FAULT_PRI); // RULE17
                `SCSP_OFF_SVC_PRI:
                    svc_pri_r <= lane_merge(svc_pri_r, pwdata, pstrb, `SCSP_MASK_SVC_PRI); // RULE18
                `SCSP_OFF_PEND_TICK_PRI:
                    pend_tick_r <= lane_merge(pend_tick_r, pwdata, pstrb, `SCSP_MASK_PEND_TICK); // RULE18
                default:
                    sleep_wake_r <= sleep_wake_r;
            endcase
        end
    end

    assign memmanage_priority             = fault_pri_r[7:4];   // RULE17
    assign busfault_priority              = fault_pri_r[15:12]; // RULE17
    assign usagefault_priority            = fault_pri_r[23:20]; // RULE17
    assign supervisor_call_priority_field = svc_pri_r[31:28];   // RULE18
    assign pendable_service_priority      = pend_tick_r[23:20]; // RULE18
    assign tick_timer_priority            = pend_tick_r[31:28]; // RULE18

    // event latch and low-power state machine
    always @*
    begin
        state_nxt       = state_r;
        event_latch_nxt = event_latch_r;
        case (state_r)
            ST_RUN:
            begin
                if (wait_for_event_instr)
                begin
                    if (event_latch_r | wake_src)
                        event_latch_nxt = 1'b0;            // RULE3
                    else
                        state_nxt = ST_WFE;
                end
                else if (wake_src)
                    event_latch_nxt = 1'b1;                // RULE3
                else if (handler_to_thread & sleep_wake_r[`SCSP_SW_SLEEP_AFTER])
                    state_nxt = ST_EXIT;                   // RULE6
            end
            ST_WFE:
            begin
                if (wake_src)
                    state_nxt = ST_RUN;                    // RULE3
            end
            ST_EXIT:
            begin
                if (pend_en)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RUN;
        endcase
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            state_r       <= ST_RUN;
            event_latch_r <= 1'b0;
            pend_d_r      <= {NUM_IRQ{1'b0}};
            wfe_done      <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            event_latch_r <= event_latch_nxt;
            pend_d_r      <= irq_pending;
            wfe_done      <= ((state_r == ST_RUN) & wait_for_event_instr & (event_latch_r | wake_src))
                           | ((state_r == ST_WFE) & wake_src);
        end
    end

    assign low_power  = (state_r != ST_RUN);
    assign deep_sleep = low_power & sleep_wake_r[`SCSP_SW_DEEP_SEL]; // RULE5

    // trap and entry decisions, registered one cycle after the core's request
    always @(posedge mclk)
    begin
        if (rst)
        begin
            stack_realign   <= 1'b0;
            return_readjust <= 1'b0;
        end
        else
        begin
            // an sp with entry_sp bit 2 set needs four bytes of padding only in eight-byte mode
            if (exc_entry)
                stack_realign <= trap_cfg_r[`SCSP_TC_STACK_ALIGN8] & entry_sp[2]; // RULE7 RULE8
            return_readjust <= exception_return_code & stacked_realign;                      // RULE8
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            lockup            <= 1'b0;
            bus_fault_take    <= 1'b0;
            bus_fault_ignored <= 1'b0;
        end
        else
        begin
            // lockup holds until reset; nothing short of reset recovers the core
            if (data_bus_fault & exec_pri_negative & ~trap_cfg_r[`SCSP_TC_BF_IGNORE])
                lockup <= 1'b1;                                                   // RULE9
            bus_fault_take    <= data_bus_fault & ~exec_pri_negative;
            bus_fault_ignored <= data_bus_fault & exec_pri_negative
                               & trap_cfg_r[`SCSP_TC_BF_IGNORE];                  // RULE9
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            divide_fault         <= 1'b0;
            divide_quot_zero     <= 1'b0;
            usage_fault_misalign <= 1'b0;
        end
        else
        begin
            divide_fault      <= divide_zero & trap_cfg_r[`SCSP_TC_DIV_ZERO_TRAP];  // RULE10
            divide_quot_zero  <= divide_zero & ~trap_cfg_r[`SCSP_TC_DIV_ZERO_TRAP]; // RULE10
            usage_fault_misalign <= access_misaligned
                                  & (access_multi_dword                           // RULE12
                                   | trap_cfg_r[`SCSP_TC_MISALIGN_TRAP]);         // RULE11
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            trigger_grant  <= 1'b0;
            trigger_refuse <= 1'b0;
        end
        else
        begin
            trigger_grant  <= trigger_write
                            & (~trigger_unpriv | trap_cfg_r[`SCSP_TC_UNPRIV_TRIG]);  // RULE13
            trigger_refuse <= trigger_write & trigger_unpriv
                            & ~trap_cfg_r[`SCSP_TC_UNPRIV_TRIG];                    // RULE13
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            thread_return_ok    <= 1'b0;
            thread_return_fault <= 1'b0;
        end
        else
        begin
            thread_return_ok    <= return_to_thread
                                 & (~other_active | trap_cfg_r[`SCSP_TC_THREAD_ANY]);  // RULE14
            thread_return_fault <= return_to_thread & other_active
                                 & ~trap_cfg_r[`SCSP_TC_THREAD_ANY];                 // RULE14
        end
    end

    // preemption: group bits only, smaller value is more urgent
    always @*
    begin
        case (cand_handler)
            3'd0:    cand_pri = {memmanage_priority, 4'h0};
            3'd1:    cand_pri = {busfault_priority, 4'h0};
            3'd2:    cand_pri = {usagefault_priority, 4'h0};
            3'd3:    cand_pri = {supervisor_call_priority_field, 4'h0};
            3'd4:    cand_pri = {pendable_service_priority, 4'h0};
            3'd5:    cand_pri = {tick_timer_priority, 4'h0};
            default: cand_pri = 8'hff;
        endcase
        grp_mask = 8'hfe << prigroup;                                    // RULE20
    end

    always @(posedge mclk)
    begin
        if (rst)
            cand_preempts <= 1'b0;
        else
            cand_preempts <= (cand_pri & grp_mask) < (cur_exec_pri & grp_mask); // RULE19 RULE20
    end

endmodule

// ===== hw/scsp_map.vh
// Purpose: register offsets, field positions and reset values of the system control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   included by scsp_ctrl.v and by the test bench
`ifndef SCSP_MAP_VH
`define SCSP_MAP_VH

// register byte offsets
`define SCSP_OFF_SLEEP_WAKE    12'h000
`define SCSP_OFF_TRAP_CFG      12'h004
`define SCSP_OFF_FAULT_PRI     12'h008
`define SCSP_OFF_SVC_PRI       12'h00c
`define SCSP_OFF_PEND_TICK_PRI 12'h010

// sleep_wake_control fields
`define SCSP_SW_SLEEP_AFTER    1
`define SCSP_SW_DEEP_SEL       2
`define SCSP_SW_WAKE_ANY       4

// trap_and_entry_config fields
`define SCSP_TC_THREAD_ANY     0
`define SCSP_TC_UNPRIV_TRIG    1
`define SCSP_TC_MISALIGN_TRAP  3
`define SCSP_TC_DIV_ZERO_TRAP  4
`define SCSP_TC_BF_IGNORE      8
`define SCSP_TC_STACK_ALIGN8   9

// writable bit masks; everything else reads zero
`define SCSP_MASK_SLEEP_WAKE   32'h0000_0016
`define SCSP_MASK_TRAP_CFG     32'h0000_031b
`define SCSP_MASK_FAULT_PRI    32'h00f0_f0f0
`define SCSP_MASK_SVC_PRI      32'hf000_0000
`define SCSP_MASK_PEND_TICK    32'hf0f0_0000

// reset values
`define SCSP_RST_SLEEP_WAKE    32'h0000_0000
`define SCSP_RST_TRAP_CFG      32'h0000_0000
`define SCSP_RST_PRI           32'h0000_0000

// position of the realignment flag in the stacked status word
`define SCSP_PSR_REALIGN_BIT   9

`endif

// ===== test/scsp_core_model.sv
// Purpose: core-side stand-in turning bench requests into one-cycle pulses
// Assumes: requests arrive just after a rising mclk edge
// Notes:   bit n of pulse answers request code n; idle lines rest low
`timescale 1ns/1ps
module scsp_core_model (
    input  wire        mclk,
    input  wire        go,
    input  wire [3:0]  op,
    output reg  [10:0] pulse
);
    initial
        pulse = 11'h000;
    always @(posedge mclk)
        pulse <= go ? 11'h001 << op : 11'h000;
endmodule

// ===== test/scsp_ctrl_chk.sv
// Purpose: port-level properties of scsp_ctrl
// Assumes: single mclk domain, rst synchronous active high
// Notes:   register bits are out of sight, so checks tie outputs to input pulses
`timescale 1ns/1ps
module scsp_ctrl_chk (
    input wire mclk,
    input wire rst,
    input wire divide_zero,
    input wire divide_fault,
    input wire divide_quot_zero,
    input wire access_misaligned,
    input wire access_multi_dword,
    input wire usage_fault_misalign,
    input wire lockup,
    input wire data_bus_fault,
    input wire exec_pri_negative,
    input wire bus_fault_ignored,
    input wire trigger_write,
    input wire trigger_unpriv,
    input wire trigger_grant,
    input wire deep_sleep,
    input wire low_power,
    input wire send_event_instr,
    input wire wait_for_event_instr,
    input wire wfe_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_dz; divide_zero |=> divide_fault ^ divide_quot_zero; endproperty
    a_dz: assert property (p_dz) else $error("divide outcome missing");
    property p_md; access_misaligned && access_multi_dword |=> usage_fault_misalign; endproperty
    a_md: assert property (p_md) else $error("multi access not faulted");
    property p_lk; lockup |=> lockup; endproperty
    a_lk: assert property (p_lk) else $error("lockup released");
    property p_bf; data_bus_fault && exec_pri_negative |=> lockup || bus_fault_ignored; endproperty
    a_bf: assert property (p_bf) else $error("high priority bus fault lost");
    property p_tg; trigger_write && !trigger_unpriv |=> trigger_grant; endproperty
    a_tg: assert property (p_tg) else $error("privileged trigger refused");
    property p_ds; deep_sleep |-> low_power; endproperty
    a_ds: assert property (p_ds) else $error("deep sleep while running");
    // a wait in the same cycle as the event would consume the latch early
    property p_ev;
        !low_power && send_event_instr && !wait_for_event_instr
        ##1 !wait_for_event_instr [*3] ##1 wait_for_event_instr |=> wfe_done;
    endproperty
    a_ev: assert property (p_ev) else $error("latched event ignored");
    property p_wd; wfe_done |-> !low_power; endproperty
    a_wd: assert property (p_wd) else $error("wait ended but still low power");
    c_wk: cover property (wfe_done);
    c_lk: cover property ($rose(lockup));
    c_bi: cover property (bus_fault_ignored);
endmodule

bind scsp_ctrl scsp_ctrl_chk u_chk (
    .mclk, .rst, .divide_zero, .divide_fault, .divide_quot_zero, .access_misaligned, .access_multi_dword,
    .usage_fault_misalign, .lockup, .data_bus_fault, .exec_pri_negative, .bus_fault_ignored, .trigger_write,
    .trigger_unpriv, .trigger_grant, .deep_sleep, .low_power, .send_event_instr, .wait_for_event_instr, .wfe_done
);

// ===== test/test_scsp_ctrl.sv
// Purpose: self-checking bench for scsp_ctrl
// Assumes: core pulses come from scsp_core_model
// Notes:   lockup is sticky, so it is provoked last and cleared by a second reset
`timescale 1ns/1ps
`include "scsp_map.vh"
module test_scsp_ctrl;
    reg         mclk, rst, psel, penable, pwrite, go, stacked_realign, access_multi_dword;
    reg         exec_pri_negative, trigger_unpriv, other_active;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, irq_pending, irq_enable, entry_sp, seed, v;
    reg  [3:0]  pstrb, op;
    reg  [2:0]  prigroup, cand_handler;
    reg  [7:0]  cur_exec_pri;
    reg  [31:0] mir [0:4];
    reg  [31:0] msk [0:4];
    reg  [32:0] qr [$];
    reg  [10:0] qp [$];
    wire [10:0] pulse, pv;
    wire [31:0] prdata;
    wire        pready, pslverr, low_power, deep_sleep, stack_realign, lockup, cand_preempts;
    wire [3:0]  pm, pb, pu, ps, pp, pt;
    integer     n_fail, n_checks, i, t;

    scsp_core_model u_core (.mclk, .go, .op, .pulse);
    scsp_ctrl DUT (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot(3'h0), .pready, .prdata,
        .pslverr, .irq_pending, .irq_enable, .wait_for_event_instr(pulse[0]), .send_event_instr(pulse[1]),
        .ext_event(pulse[2]), .handler_to_thread(pulse[3]), .low_power, .deep_sleep, .wfe_done(pv[10]),
        .exc_entry(pulse[4]), .entry_sp, .exception_return_code(pulse[5]), .stacked_realign, .stack_realign,
        .return_readjust(pv[9]), .data_bus_fault(pulse[6]), .exec_pri_negative, .lockup,
        .bus_fault_take(pv[8]), .bus_fault_ignored(pv[7]), .divide_zero(pulse[7]), .divide_fault(pv[6]),
        .divide_quot_zero(pv[5]), .access_misaligned(pulse[8]), .access_multi_dword,
        .usage_fault_misalign(pv[4]), .trigger_write(pulse[9]), .trigger_unpriv, .trigger_grant(pv[3]),
        .trigger_refuse(pv[2]), .return_to_thread(pulse[10]), .other_active, .thread_return_ok(pv[1]),
        .thread_return_fault(pv[0]), .memmanage_priority(pm), .busfault_priority(pb),
        .usagefault_priority(pu), .supervisor_call_priority_field(ps), .pendable_service_priority(pp),
        .tick_timer_priority(pt), .prigroup, .cand_handler, .cur_exec_pri, .cand_preempts
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task chk(input [32:0] got, input [32:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task conclude;
        begin
            n_fail = n_fail + qr.size() + qp.size();
            if (n_fail == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // notes are taken before the bus moves, so the monitor never runs ahead of them
    task acc(input w, input integer r, input [31:0] d, input [3:0] s);
        integer b;
        begin
            for (b = 0; b < 4; b = b + 1)
                if (w && s[b])
                    mir[r][8*b+:8] = d[8*b+:8] & msk[r][8*b+:8];
            if (!w)
                qr.push_back(r < 5 ? {1'b0, mir[r]} : {1'b1, 32'h0});
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {r[9:0], 2'b00};
            pwdata <= d;
            pstrb <= s;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1)
                @(posedge mclk);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task core(input [3:0] o, input [10:0] e);
        begin
            if (e != 11'h000)
                qp.push_back(e);
            go <= 1'b1;
            op <= o;
            @(posedge mclk);
            go <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask

    task pri;
        begin
            chk({pm, pb, pu}, {mir[2][7:4], mir[2][15:12], mir[2][23:20]});
            chk({ps, pp, pt}, {mir[3][31:28], mir[4][23:20], mir[4][31:28]});
        end
    endtask

    always @(posedge mclk)
    begin
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, qr.pop_front());
        if (|pv)
            chk(pv, qp.pop_front());
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail = n_fail + 1;
        conclude;
    end

    initial
    begin
        {psel, penable, pwrite, go, stacked_realign, access_multi_dword, exec_pri_negative} = 7'h00;
        {trigger_unpriv, other_active, paddr, pwdata, pstrb, op} = 54'h0;
        {irq_pending, irq_enable, entry_sp, prigroup, cand_handler, cur_exec_pri} = 110'h0;
        seed = 32'h77dab436;
        n_fail = 0;
        n_checks = 0;
        msk[0] = `SCSP_MASK_SLEEP_WAKE;
        msk[1] = `SCSP_MASK_TRAP_CFG;
        msk[2] = `SCSP_MASK_FAULT_PRI;
        msk[3] = `SCSP_MASK_SVC_PRI;
        msk[4] = `SCSP_MASK_PEND_TICK;
        for (i = 0; i < 5; i = i + 1)
            mir[i] = 32'h0;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (i = 0; i < 6; i = i + 1)
            acc(1'b0, i, 32'h0, 4'h0);
        for (i = 0; i < 5; i = i + 1)
        begin
            acc(1'b1, i, 32'hffffffff, 4'hf);
            acc(1'b0, i, 32'h0, 4'h0);
        end
        pri;
        repeat (12)
        begin
            v = $random(seed);
            i = 2 + v[5:4] % 3;
            acc(1'b1, i, v, v[3:0]);
            acc(1'b0, i, 32'h0, 4'h0);
            pri;
        end
        for (t = 0; t < 2; t = t + 1)
        begin
            acc(1'b1, 1, t ? 32'hffffffff : 32'h0, 4'hf);
            core(7, t ? 11'h040 : 11'h020);
            core(8, t ? 11'h010 : 11'h000);
            access_multi_dword <= 1'b1;
            core(8, 11'h010);
            access_multi_dword <= 1'b0;
            trigger_unpriv <= 1'b1;
            core(9, t ? 11'h008 : 11'h004);
            trigger_unpriv <= 1'b0;
            core(9, 11'h008);
            other_active <= 1'b1;
            core(10, t ? 11'h002 : 11'h001);
            other_active <= 1'b0;
            core(10, 11'h002);
            core(6, 11'h100);
            entry_sp <= 32'h4;
            core(4, 11'h000);
            chk(stack_realign, t);
            entry_sp <= 32'h0;
            core(4, 11'h000);
            chk(stack_realign, 0);
            stacked_realign <= 1'b1;
            core(5, 11'h200);
            stacked_realign <= 1'b0;
        end
        exec_pri_negative <= 1'b1;
        core(6, 11'h080);
        acc(1'b1, 0, 32'h0, 4'hf);
        core(1, 11'h000);
        core(0, 11'h400);
        chk(low_power, 0);
        core(0, 11'h000);
        chk({deep_sleep, low_power}, 2'b01);
        irq_pending <= 32'h8;
        repeat (3) @(posedge mclk);
        chk(low_power, 1);
        qp.push_back(11'h400);
        irq_enable <= 32'h20;
        irq_pending <= 32'h28;
        repeat (3) @(posedge mclk);
        chk(low_power, 0);
        irq_pending <= 32'h0;
        acc(1'b1, 0, 32'h14, 4'hf);
        core(0, 11'h000);
        chk({deep_sleep, low_power}, 2'b11);
        qp.push_back(11'h400);
        irq_pending <= 32'h8;
        repeat (3) @(posedge mclk);
        chk(low_power, 0);
        core(0, 11'h000);
        core(2, 11'h400);
        acc(1'b1, 0, 32'h2, 4'hf);
        core(3, 11'h000);
        chk(low_power, 1);
        irq_pending <= 32'h28;
        repeat (3) @(posedge mclk);
        chk(low_power, 0);
        acc(1'b1, 0, 32'h0, 4'hf);
        core(3, 11'h000);
        chk(low_power, 0);
        acc(1'b1, 3, 32'h80000000, 4'h8);
        cand_handler <= 3'h3;
        for (i = 0; i < 16; i = i + 1)
        begin
            v = $random(seed);
            prigroup <= i[2:0];
            cur_exec_pri <= v[7:0];
            repeat (2) @(posedge mclk);
            chk(cand_preempts, (8'h80 >> (i[2:0] + 1)) < (v[7:0] >> (i[2:0] + 1)));
        end
        cand_handler <= 3'h6;
        repeat (2) @(posedge mclk);
        chk(cand_preempts, 0);
        acc(1'b1, 1, 32'h0, 4'hf);
        core(6, 11'h000);
        chk(lockup, 1);
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk(lockup, 0);
        mir[2] = 32'h0;
        acc(1'b0, 2, 32'h0, 4'h0);
        conclude;
    end
endmodule
